// [mclk_consts.vh]
// constants for the multi-speed oscillator and peripheral clock/reset block
// assumes inclusion by the design files of this block only
// Functional notes
// - range field decodes twelve codes, reset 0110
// - range writes above 1011 are refused
// - range select set by one, zero ignored
// - select clears on reset or standby exit
// - lock loop set needs crystal on, ready
// - lock loop cleared on crystal off/failure
// - ready drops six oscillator cycles after off
// - enable cleared entering stop, standby, shutdown
// - enable forced on leaving standby, shutdown
// - forced on stop exit wakeup zero, fault
// - enable held while oscillator clocks system
// - peripheral reset bits: one resets, zero none
// - firewall enable set only, hardware clears
// - sleep enable register 0x68, reset 0x00011303
// - sleep register byte lanes, no wait
// - option bits steer second ram erase, parity
// - option bits choose reset on mode entry
// - option bits freeze or start watchdogs
`ifndef MCLK_CONSTS_VH
`define MCLK_CONSTS_VH
`define MCLK_OFS_OSC_CTRL   8'h00
`define MCLK_OFS_AHB_RST    8'h2C
`define MCLK_OFS_APB_CLKEN  8'h60
`define MCLK_OFS_SLEEP_EN   8'h68
`define MCLK_OFS_OPTIONS    8'h80
`define MCLK_SLEEP_RST      32'h0001_1303
`define MCLK_SLEEP_MASK     32'h0001_1303
`define MCLK_AHB_RST_MASK   32'h0005_209F
`define MCLK_APB_SW_MASK    32'h0000_1C01
`define MCLK_OPT_RST        32'h033F_7000
`define MCLK_OPT_MASK       32'h030F_7000
`define MCLK_RANGE_RST      4'h6
`define MCLK_RANGE_MAX      4'hB
`define MCLK_BIT_ON         0
`define MCLK_BIT_RDY        1
`define MCLK_BIT_PLLEN      2
`define MCLK_BIT_RGSEL      3
`define MCLK_RANGE_LSB      4
`define MCLK_BIT_FIREWALL_CLOCK_ENABLE       7
`define MCLK_OFF_CYCLES     3'd6
`define MCLK_SETTLE_NS      400
`define MCLK_CLK_NS         40
`endif

// [mclk_ready_tracker.v]
// oscillator ready tracker: settles on enable, drops after off delay
// assumes osc clock edges arrive as a synchronous one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
`include "mclk_consts.vh"
module mclk_ready_tracker (
  input  wire i_clk,      // core clock
  input  wire i_rst_n,    // synchronised reset, active low
  input  wire i_enable,   // oscillator enable
  input  wire i_osc_tick, // one oscillator clock edge
  output reg  o_ready     // oscillator ready flag
);
  localparam integer SETTLE = (`MCLK_SETTLE_NS + `MCLK_CLK_NS - 1)
                              / `MCLK_CLK_NS;
  reg [7:0] settle_r;
  reg [2:0] off_r;
  // settle count while on, six osc ticks after off
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_r <= 8'h00;
      off_r    <= 3'd0;
      o_ready  <= 1'b0;
    end else if (i_enable) begin
      off_r <= 3'd0;
      if (settle_r == SETTLE[7:0]) begin
        o_ready <= 1'b1;
      end else begin
        settle_r <= settle_r + 8'h01;
      end
    end else begin
      settle_r <= 8'h00;
      if (o_ready && i_osc_tick) begin
        if (off_r == `MCLK_OFF_CYCLES - 3'd1) begin
          o_ready <= 1'b0;
          off_r   <= 3'd0;
        end else begin
          off_r <= off_r + 3'd1;
        end
      end
    end
  end
endmodule // mclk_ready_tracker
`default_nettype wire

// [mclk_clock_reset.v]
// reset and clock control: oscillator control, peripheral resets,
// clock enables, sleep enables and option decode over avalon-mm
// assumes power sequencing and oscillators sit outside this block
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mclk_consts.vh"
module mclk_clock_reset (
  input  wire        i_core_clk,       // 25 MHz core clock
  input  wire        i_rst_n,          // async reset, active low
  input  wire [7:0]  i_address,        // byte address
  input  wire        i_read,           // avalon read
  input  wire        i_write,          // avalon write
  input  wire [3:0]  i_byteenable,     // avalon byte enables
  input  wire [31:0] i_writedata,      // avalon write data
  output wire        o_waitrequest,    // avalon wait, never asserted
  output reg  [31:0] o_readdata,       // avalon read data
  input  wire [3:0]  i_standby_range,  // standby range field
  input  wire        i_lsc_enable,     // low speed crystal enable
  input  wire        i_lsc_ready,      // low speed crystal ready
  input  wire        i_lsc_fail,       // crystal failure detect
  input  wire        i_enter_lowpower, // entering stop/standby/shutdown
  input  wire        i_exit_standby,   // leaving standby or shutdown
  input  wire        i_exit_stop,      // leaving stop mode
  input  wire        i_stop_wakeup_sel,// stop wakeup clock select
  input  wire        i_hse_fail,       // high speed osc failure
  input  wire        i_osc_is_sysclk,  // osc drives system clock
  input  wire        i_fw_clear,       // hardware firewall clear
  input  wire        i_osc_tick,       // oscillator clock strobe
  input  wire [31:0] i_option_bytes,   // option word at release
  output reg  [3:0]  o_active_range,   // range in use
  output reg         o_osc_enable,     // oscillator on
  output reg         o_lock_loop_en,   // locking loop on
  output reg  [31:0] o_periph_reset,   // peripheral resets
  output reg  [31:0] o_periph_clk_en,  // apb clock enables
  output reg  [31:0] o_sleep_clk_en,   // sleep/stop clock enables
  output reg         o_ram2_erase,     // erase second ram on reset
  output reg         o_ram2_parity_en, // second ram parity on
  output reg  [2:0]  o_reset_on_entry, // stop/standby/shutdown reset
  output reg  [1:0]  o_iwdg_freeze,    // standby,stop watchdog freeze
  output reg  [1:0]  o_wdg_sw_start    // window,indep software start
);
  localparam [1:0] S_BOOT = 2'b01;
  localparam [1:0] S_RUN  = 2'b10;

  reg        rs1_r;
  reg        rs2_r;
  wire       rst_n = rs2_r;
  reg  [1:0] state_r;
  reg  [3:0] run_osc_range_field_r;
  reg        range_source_select_r;
  reg  [31:0] opt_r;
  wire       osc_ready_flag;

  // byte lane merge, reused by every register write
  function [31:0] mclk_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer k;
    begin
      mclk_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          mclk_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // register hit decode
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end

  assign o_waitrequest = 1'b0;

  wire wr_osc   = i_write && hit(i_address, `MCLK_OFS_OSC_CTRL);
  wire wr_rst   = i_write && hit(i_address, `MCLK_OFS_AHB_RST);
  wire wr_clk   = i_write && hit(i_address, `MCLK_OFS_APB_CLKEN);
  wire wr_sleep = i_write && hit(i_address, `MCLK_OFS_SLEEP_EN);
  wire [31:0] osc_wd = mclk_merge(32'h0000_0000, i_writedata,
                                  i_byteenable);
  wire        be0 = i_byteenable[0];
  wire        fw_set = wr_clk && be0 && i_writedata[`MCLK_BIT_FIREWALL_CLOCK_ENABLE];
  wire [3:0]  wr_range = osc_wd[`MCLK_RANGE_LSB +: 4];

  // oscillator control register fields
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_osc_range_field_r <= `MCLK_RANGE_RST;
      range_source_select_r <= 1'b0;
      o_lock_loop_en        <= 1'b0;
      o_osc_enable          <= 1'b1;
    end else begin
      if (wr_osc && be0 && wr_range <= `MCLK_RANGE_MAX) begin
        run_osc_range_field_r <= wr_range;
      end
      if (i_exit_standby) begin
        range_source_select_r <= 1'b0;
      end else if (wr_osc && be0 && osc_wd[`MCLK_BIT_RGSEL]) begin
        range_source_select_r <= 1'b1;
      end
      if (!i_lsc_enable || i_lsc_fail) begin
        o_lock_loop_en <= 1'b0;
      end else if (wr_osc && be0) begin
        o_lock_loop_en <= osc_wd[`MCLK_BIT_PLLEN] &&
                          i_lsc_ready;
      end
      if (i_exit_standby || (i_exit_stop && !i_stop_wakeup_sel) ||
          i_hse_fail || i_osc_is_sysclk) begin
        o_osc_enable <= 1'b1;
      end else if (i_enter_lowpower) begin
        o_osc_enable <= 1'b0;
      end else if (wr_osc && be0) begin
        o_osc_enable <= osc_wd[`MCLK_BIT_ON];
      end
    end
  end

  // active range follows the source select
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_active_range <= `MCLK_RANGE_RST;
    end else begin
      o_active_range <= range_source_select_r ? run_osc_range_field_r
                        : i_standby_range;
    end
  end

  // ready flag only from stability logic
  mclk_ready_tracker u_ready (
    .i_clk      (i_core_clk),
    .i_rst_n    (rst_n),
    .i_enable   (o_osc_enable),
    .i_osc_tick (i_osc_tick),
    .o_ready    (osc_ready_flag)
  );

  // peripheral resets, clock enables and sleep enables
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_periph_reset          <= 32'h0000_0000;
      o_periph_clk_en         <= 32'h0000_0000;
      o_sleep_clk_en          <= `MCLK_SLEEP_RST;
    end else begin
      if (wr_rst) begin
        o_periph_reset <= mclk_merge(o_periph_reset, i_writedata,
                          i_byteenable) & `MCLK_AHB_RST_MASK;
      end
      if (wr_clk) begin
        o_periph_clk_en <= mclk_merge(o_periph_clk_en, i_writedata,
                           i_byteenable) & `MCLK_APB_SW_MASK;
      end
      // firewall bit: software only sets, hardware clears, set wins
      o_periph_clk_en[`MCLK_BIT_FIREWALL_CLOCK_ENABLE] <= fw_set ||
          (o_periph_clk_en[`MCLK_BIT_FIREWALL_CLOCK_ENABLE] && !i_fw_clear);
      if (wr_sleep) begin
        o_sleep_clk_en <= mclk_merge(o_sleep_clk_en, i_writedata,
                          i_byteenable) & `MCLK_SLEEP_MASK;
      end
    end
  end

  // option word caught after reset release
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_BOOT;
      opt_r   <= `MCLK_OPT_RST;
    end else begin
      case (state_r)
        S_BOOT: begin
          opt_r   <= i_option_bytes & `MCLK_OPT_MASK;
          state_r <= S_RUN;
        end
        S_RUN: state_r <= S_RUN;
        default: state_r <= S_BOOT;
      endcase
    end
  end

  // option decode
  always @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_ram2_erase     <= 1'b0;
      o_ram2_parity_en <= 1'b0;
      o_reset_on_entry <= 3'b000;
      o_iwdg_freeze    <= 2'b00;
      o_wdg_sw_start   <= 2'b11;
    end else begin
      o_ram2_erase     <= !opt_r[25];
      o_ram2_parity_en <= !opt_r[24];
      o_reset_on_entry <= ~opt_r[14:12];
      o_iwdg_freeze    <= ~opt_r[18:17];
      o_wdg_sw_start   <= {opt_r[19], opt_r[16]};
    end
  end

  // read mux straight from the register flops, unmapped reads zero;
  // data must stand at the accepting edge since no wait is inserted
  always @* begin
    case (i_address)
      `MCLK_OFS_OSC_CTRL:  o_readdata = {24'h00_0000,
          run_osc_range_field_r, range_source_select_r,
          o_lock_loop_en, osc_ready_flag, o_osc_enable};
      `MCLK_OFS_AHB_RST:   o_readdata = o_periph_reset;
      `MCLK_OFS_APB_CLKEN: o_readdata = o_periph_clk_en;
      `MCLK_OFS_SLEEP_EN:  o_readdata = o_sleep_clk_en;
      `MCLK_OFS_OPTIONS:   o_readdata = opt_r;
      default:             o_readdata = 32'h0000_0000;
    endcase
  end
endmodule // mclk_clock_reset
`default_nettype wire

// [mclk_clock_reset_checker.sv]
// port level checks for the clock and reset control block
// assumes one core clock domain and a bind onto the top module
`timescale 1ns/1ps
`default_nettype none
module mclk_clock_reset_checker (
  input wire logic        i_core_clk,       // clock
  input wire logic        i_rst_n,          // reset
  input wire logic        i_lsc_enable,     // crystal on
  input wire logic        i_lsc_ready,      // crystal ready
  input wire logic        i_lsc_fail,       // crystal fault
  input wire logic        i_enter_lowpower, // mode entry
  input wire logic        i_exit_standby,   // standby exit
  input wire logic        i_exit_stop,      // stop exit
  input wire logic        i_stop_wakeup_sel,// wakeup select
  input wire logic        i_hse_fail,       // fast osc fault
  input wire logic        i_osc_is_sysclk,  // osc is sysclk
  input wire logic        i_fw_clear,       // firewall clear
  input wire logic        o_waitrequest,    // bus wait
  input wire logic [3:0]  o_active_range,   // range in use
  input wire logic        o_osc_enable,     // osc on
  input wire logic        o_lock_loop_en,   // lock loop
  input wire logic [31:0] o_periph_reset,   // resets
  input wire logic [31:0] o_periph_clk_en,  // clock enables
  input wire logic [31:0] o_sleep_clk_en    // sleep enables
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // bus timing and register masks
  property p_no_wait; o_waitrequest == 1'b0; endproperty
  a_no_wait: assert property (p_no_wait)
    else $error("wait state seen");
  property p_range; o_active_range <= 4'hB; endproperty
  a_range: assert property (p_range)
    else $error("illegal range in use");
  property p_rst_bits; (o_periph_reset & ~32'h0005_209F) == 0; endproperty
  a_rst_bits: assert property (p_rst_bits)
    else $error("reset bit outside map");
  property p_clk_bits; (o_periph_clk_en & ~32'h0000_1C81) == 0; endproperty
  a_clk_bits: assert property (p_clk_bits)
    else $error("clock bit outside map");
  property p_slp_bits; (o_sleep_clk_en & ~32'h0001_1303) == 0; endproperty
  a_slp_bits: assert property (p_slp_bits)
    else $error("sleep bit outside map");
  // lock loop gating by the crystal
  property p_pll_set;
    $rose(o_lock_loop_en) |-> $past(i_lsc_enable && i_lsc_ready);
  endproperty
  a_pll_set: assert property (p_pll_set)
    else $error("lock loop set without crystal");
  property p_pll_clr; (!i_lsc_enable || i_lsc_fail) |=> !o_lock_loop_en;
  endproperty
  a_pll_clr: assert property (p_pll_clr)
    else $error("lock loop kept after crystal loss");
  // oscillator enable forcing, firewall enable cleared by hardware only
  property p_lp_off;
    (i_enter_lowpower && !i_exit_standby && !i_exit_stop && !i_hse_fail
     && !i_osc_is_sysclk) |=> !o_osc_enable;
  endproperty
  a_lp_off: assert property (p_lp_off)
    else $error("osc kept on in low power");
  property p_force_on;
    (i_exit_standby || i_hse_fail || (i_exit_stop && !i_stop_wakeup_sel)
     || i_osc_is_sysclk) |=> o_osc_enable;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("osc not forced on");
  property p_fw_keep; $fell(o_periph_clk_en[7]) |-> $past(i_fw_clear);
  endproperty
  a_fw_keep: assert property (p_fw_keep)
    else $error("firewall enable cleared by software");
endmodule // mclk_clock_reset_checker
bind mclk_clock_reset mclk_clock_reset_checker i_chk (.i_core_clk, .i_rst_n,
  .i_lsc_enable, .i_lsc_ready, .i_lsc_fail, .i_enter_lowpower,
  .i_exit_standby, .i_exit_stop, .i_stop_wakeup_sel, .i_hse_fail,
  .i_osc_is_sysclk, .i_fw_clear, .o_waitrequest, .o_active_range,
  .o_osc_enable, .o_lock_loop_en, .o_periph_reset, .o_periph_clk_en,
  .o_sleep_clk_en);
`default_nettype wire

// [test_mclk_clock_reset.sv]
// self-checking bench for the clock and reset control block
// assumes the checker is bound in and a 25 MHz core clock
`timescale 1ns/1ps
`default_nettype none
module test_mclk_clock_reset;
  logic i_core_clk = 0, i_rst_n = 0, i_read = 0, i_write = 0, i_osc_tick = 0;
  logic i_lsc_enable = 0, i_lsc_ready = 0, i_lsc_fail = 0, i_hse_fail = 0;
  logic i_enter_lowpower = 0, i_exit_standby = 0, i_exit_stop = 0;
  logic i_stop_wakeup_sel = 0, i_osc_is_sysclk = 0, i_fw_clear = 0;
  logic [7:0]  i_address = 8'h00;
  logic [3:0]  i_byteenable = 4'h0, i_standby_range = 4'h3, o_active_range;
  logic [31:0] i_writedata = 0, i_option_bytes = 32'h0101_2000, o_readdata;
  logic [31:0] o_periph_reset, o_periph_clk_en, o_sleep_clk_en;
  logic        o_waitrequest, o_osc_enable, o_lock_loop_en, o_ram2_erase;
  logic        o_ram2_parity_en;
  logic [2:0]  o_reset_on_entry;
  logic [1:0]  o_iwdg_freeze, o_wdg_sw_start;
  logic [3:0]  exp_r;
  logic [31:0] rdata = 0;
  int          failures = 0, comparisons = 0;
  mclk_clock_reset i_mclk_clock_reset (.i_core_clk, .i_rst_n, .i_address,
    .i_read, .i_write, .i_byteenable, .i_writedata, .o_waitrequest,
    .o_readdata, .i_standby_range, .i_lsc_enable, .i_lsc_ready, .i_lsc_fail,
    .i_enter_lowpower, .i_exit_standby, .i_exit_stop, .i_stop_wakeup_sel,
    .i_hse_fail, .i_osc_is_sysclk, .i_fw_clear, .i_osc_tick, .i_option_bytes,
    .o_active_range, .o_osc_enable, .o_lock_loop_en, .o_periph_reset,
    .o_periph_clk_en, .o_sleep_clk_en, .o_ram2_erase, .o_ram2_parity_en,
    .o_reset_on_entry, .o_iwdg_freeze, .o_wdg_sw_start);
  // 40 ns core clock
  initial forever #20 i_core_clk = ~i_core_clk;
  task automatic final_report;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // edges, then settle past the update
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  // avalon access held until waitrequest is seen low
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge i_core_clk);
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= be;
    do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
    rdata = o_readdata; // taken at the accepting edge
    i_write <= 1'b0;
    i_read <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    acc(1'b0, a, 0, 4'hF);
    chk(rdata & m, e & m);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge i_core_clk) i_osc_tick <= 1'b1;
      @(posedge i_core_clk) i_osc_tick <= 1'b0;
    end
  endtask
  // watchdog on the whole run
  initial begin
    #400_000;
    failures++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    cyc(20);
    rd(8'h00, 32'h0000_0063, 32'h0000_00FF);
    chk(o_active_range, 32'h3);
    rd(8'h68, 32'h0001_1303, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0101_2000, 32'hFFFF_FFFF);
    chk({o_ram2_erase, o_ram2_parity_en, o_reset_on_entry, o_iwdg_freeze,
         o_wdg_sw_start}, 32'h15D);
    // every range code, written while on and ready
    exp_r = 4'h6;
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, 8'h00, {24'h0, i[3:0], 4'h9}, 4'h1);
      if (i < 12) exp_r = i[3:0];
      cyc(2);
      chk(o_active_range, exp_r);
    end
    acc(1'b1, 8'h00, 32'h0000_00B1, 4'h1);
    rd(8'h00, 32'h0000_00B9, 32'h0000_00FD);
    @(posedge i_core_clk) i_exit_standby <= 1'b1;
    @(posedge i_core_clk) i_exit_standby <= 1'b0;
    cyc(2);
    chk(o_active_range, 32'h3);
    rd(8'h00, 32'h0, 32'h0000_0008);
    // lock loop needs the crystal
    acc(1'b1, 8'h00, 32'h0000_00B5, 4'h1);
    chk(o_lock_loop_en, 0);
    @(posedge i_core_clk) {i_lsc_enable, i_lsc_ready} <= 2'b11;
    acc(1'b1, 8'h00, 32'h0000_00B5, 4'h1);
    chk(o_lock_loop_en, 1);
    @(posedge i_core_clk) i_lsc_enable <= 1'b0;
    cyc(2);
    chk(o_lock_loop_en, 0);
    @(posedge i_core_clk) i_lsc_enable <= 1'b1;
    acc(1'b1, 8'h00, 32'h0000_00B5, 4'h1);
    @(posedge i_core_clk) i_lsc_fail <= 1'b1;
    @(posedge i_core_clk) i_lsc_fail <= 1'b0;
    cyc(1);
    chk(o_lock_loop_en, 0);
    // peripheral resets, clock enables, sleep lanes
    acc(1'b1, 8'h2C, 32'hFFFF_FFFF, 4'hF);
    rd(8'h2C, 32'h0005_209F, 32'hFFFF_FFFF);
    chk(o_periph_reset, 32'h0005_209F);
    acc(1'b1, 8'h2C, 32'h0, 4'hF);
    chk(o_periph_reset, 32'h0);
    acc(1'b1, 8'h60, 32'hFFFF_FFFF, 4'hF);
    chk(o_periph_clk_en, 32'h0000_1C81);
    acc(1'b1, 8'h60, 32'h0, 4'hF);
    chk(o_periph_clk_en, 32'h0000_0080);
    @(posedge i_core_clk) i_fw_clear <= 1'b1;
    @(posedge i_core_clk) i_fw_clear <= 1'b0;
    cyc(1);
    chk(o_periph_clk_en, 32'h0);
    acc(1'b1, 8'h68, 32'h0, 4'h1);
    chk(o_sleep_clk_en, 32'h0001_1300);
    acc(1'b1, 8'h68, 32'h0, 4'hC);
    rd(8'h68, 32'h0000_1300, 32'hFFFF_FFFF);
    // low power entry and hardware force-on
    @(posedge i_core_clk) i_enter_lowpower <= 1'b1;
    @(posedge i_core_clk) {i_enter_lowpower, i_stop_wakeup_sel} <= 2'b01;
    @(posedge i_core_clk) i_exit_stop <= 1'b1;
    @(posedge i_core_clk) {i_exit_stop, i_stop_wakeup_sel} <= 2'b00;
    cyc(1);
    chk(o_osc_enable, 0);
    @(posedge i_core_clk) i_exit_stop <= 1'b1;
    @(posedge i_core_clk) i_exit_stop <= 1'b0;
    cyc(1);
    chk(o_osc_enable, 1);
    @(posedge i_core_clk) {i_enter_lowpower, i_hse_fail} <= 2'b11;
    @(posedge i_core_clk)
      {i_enter_lowpower, i_hse_fail, i_osc_is_sysclk} <= 3'b001;
    acc(1'b1, 8'h00, 32'h0000_00B0, 4'h1);
    chk(o_osc_enable, 1);
    // ready drops on the sixth tick after switch-off
    @(posedge i_core_clk) i_osc_is_sysclk <= 1'b0;
    acc(1'b1, 8'h00, 32'h0000_00B0, 4'h1);
    chk(o_osc_enable, 0);
    tick(5);
    rd(8'h00, 32'h0000_0002, 32'h0000_0003);
    tick(1);
    cyc(2);
    rd(8'h00, 32'h0, 32'h0000_0003);
    acc(1'b1, 8'h00, 32'h0000_00B2, 4'h1);
    rd(8'h00, 32'h0, 32'h0000_0003);
    final_report;
  end
endmodule // test_mclk_clock_reset
`default_nettype wire
